// [hgs_delay.sv]
// Millisecond delay timer that restarts whenever its run condition drops
`timescale 1ns/10ps
module hgs_delay (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_clr,
   input wire logic run,
   input wire logic tick,
   input wire logic [1:0] sel,
   output logic done
);
   logic [hgs_pkg::DLY_W-1:0] cnt;
   logic [hgs_pkg::DLY_W-1:0] limit;

   assign limit = hgs_pkg::delay_ms(sel);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
         done <= 1'b0;
      end else if (por_clr || !run) begin
         cnt <= '0;
         done <= 1'b0;
      end else if (tick && !done) begin
         cnt <= cnt + 1'b1;
         done <= (cnt + 1'b1) >= limit;
      end
   end
endmodule : hgs_delay

// [hgs_gate_sel.sv]
// Gate current selection from the quick-select pins or the software code
`timescale 1ns/10ps
module hgs_gate_sel (
   input wire logic quick_select_hi,
   input wire logic quick_select_lo,
   input wire logic [3:0] gate_current_code,
   output logic [3:0] next_gate_code
);
   always_comb begin
      unique case ({quick_select_hi, quick_select_lo})
         2'b00: next_gate_code = gate_current_code;
         2'b01: next_gate_code = hgs_pkg::QS_10UA;
         2'b10: next_gate_code = hgs_pkg::QS_70UA;
         2'b11: next_gate_code = hgs_pkg::QS_150UA;
      endcase
   end
endmodule : hgs_gate_sel

// [hgs_pkg.sv]
// Constants, register map and delay decoding for the hot-swap sequencer
package hgs_pkg;
   // Register byte addresses on the APB bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_INT_STAT = 8'h08;
   localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
   localparam logic [7:0] ADDR_NVM = 8'h10;
   // Control register fields
   localparam int GC_LSB = 0;
   localparam int GC_W = 4;
   localparam int RD_LSB = 4;
   localparam int RAIL_LSB = 6;
   localparam int SEL_W = 2;
   localparam int CTRL_W = 14;
   localparam logic [3:0] GC_DEFAULT = 4'h4;
   localparam logic [13:0] CTRL_RESET = 14'h0004;
   // Quick-select forced codes: current is 10 uA times (code + 1)
   localparam logic [3:0] QS_10UA = 4'h0;
   localparam logic [3:0] QS_70UA = 4'h6;
   localparam logic [3:0] QS_150UA = 4'he;
   // Interrupt status bits
   localparam int INT_OC = 0;
   localparam int INT_PG_LOST = 1;
   localparam int INT_RST_REL = 2;
   localparam int INT_W = 3;
   // Status register fields
   localparam int ST_GATE = 0;
   localparam int ST_PG_N = 1;
   localparam int ST_RAIL_LSB = 2;
   localparam int ST_RST_N = 6;
   localparam int ST_POR = 7;
   localparam int ST_GC_LSB = 8;
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
   localparam int POR_TIME_NS = 10000;
   localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DLY_W = 13;
   localparam logic [DLY_W-1:0] DLY_100_MS = 13'h0064;
   localparam logic [DLY_W-1:0] DLY_500_MS = 13'h01f4;
   localparam logic [DLY_W-1:0] DLY_1000_MS = 13'h03e8;
   localparam logic [DLY_W-1:0] DLY_5000_MS = 13'h1388;

   // Delay select to milliseconds
   function automatic logic [DLY_W-1:0] delay_ms(input logic [1:0] sel);
      logic [DLY_W-1:0] ms;
      ms = DLY_100_MS;
      unique case (sel)
         2'h0: ms = DLY_100_MS;
         2'h1: ms = DLY_500_MS;
         2'h2: ms = DLY_1000_MS;
         2'h3: ms = DLY_5000_MS;
      endcase
      return ms;
   endfunction : delay_ms
endpackage : hgs_pkg

// [hgs_plant.sv]
// Behavioural FET stage and parallel-sequenced converters beside the sequencer
`timescale 1ns/10ps
module hgs_plant #(
   parameter int FET_DLY = 6
) (
   input wire logic pclk,
   input wire logic gate_out,
   input wire logic supply_ok_n,
   input wire logic force_drain,
   input wire logic force_gate_low,
   output logic drain_high,
   output logic gate_low,
   output logic [3:0] rail_enable_in_n
);
   logic [7:0] on_cnt;

   // The FET needs several cycles of gate drive before both sense comparators clear
   always_ff @(posedge pclk) begin
      if (!gate_out) begin
         on_cnt <= 8'h00;
      end else if (on_cnt < 8'(FET_DLY)) begin
         on_cnt <= on_cnt + 8'h01;
      end
   end
   assign drain_high = force_drain || (on_cnt < 8'(FET_DLY));
   assign gate_low = force_gate_low || (on_cnt < 8'(FET_DLY));
   // All converters are enabled together by power good
   assign rail_enable_in_n = {4{supply_ok_n}};
endmodule : hgs_plant

// [hgs_seq.sv]
// Hot-swap gate control, power-good and delayed system reset with APB registers
// Functional notes
// - The gate drives on only while no overcurrent, undervoltage or overvoltage exists.
// - Gate drive current is selectable from 10 uA to 160 uA in 10 uA steps, default 50 uA.
// - The four-bit gate code is linear from 10 uA at code 0 and resets to 0100.
// - Quick pins 00 use the code, 01 force 10 uA, 10 force 70 uA, 11 force 150 uA.
// - Software may rewrite the gate code at any time and it applies directly.
// - Power-good goes low only with no UV, OV, OC and the FET sensed fully on.
// - A drain more than 1 V above the negative supply blocks power-good.
// - A gate below its trip point blocks power-good.
// - The system reset is held active from power-on until release conditions hold.
// - With power-good and all rail goods active, reset releases after the selected delay.
// - The reset delay select gives 100 ms, 500 ms, 1 s or 5 s, default 100 ms.
// - Nonvolatile memory access is refused while power-on reset is in progress.
// - Overcurrent turns the gate off, drops every good output and records a flag.
// - Each rail good goes active its own selected delay after its enable goes active.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module hgs_seq #(
   parameter int MS_CYCLES = hgs_pkg::MS_CYCLES_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic undervoltage,
   input wire logic overvoltage,
   input wire logic overcurrent,
   input wire logic drain_high,
   input wire logic gate_low,
   input wire logic quick_select_hi,
   input wire logic quick_select_lo,
   input wire logic [3:0] rail_enable_in_n,
   output logic gate_out,
   output logic [3:0] gate_drive_current,
   output logic supply_ok_n,
   output logic [3:0] rail_good_out_n,
   output logic delayed_system_reset_n,
   output logic irq
);
   logic [hgs_pkg::CTRL_W-1:0] ctrl;
   logic [3:0] gate_current_code;
   logic [1:0] reset_delay_select;
   logic [hgs_pkg::INT_W-1:0] int_stat;
   logic [hgs_pkg::INT_W-1:0] int_mask;
   logic [hgs_pkg::INT_W-1:0] next_int_stat;
   logic [hgs_pkg::INT_W-1:0] int_ev;
   logic [31:0] nvm_word;
   logic [11:0] por_cnt;
   logic por_done;
   logic [17:0] ms_cnt;
   logic ms_tick;
   logic [3:0] rail_done;
   logic rst_done;
   logic release_ok;
   logic fet_ok;
   logic oc_q;
   logic [3:0] next_gate_code;
   logic setup;
   logic access;
   logic wr_en;
   logic addr_ok;
   logic refuse;
   logic [31:0] rd_val;

   assign gate_current_code = ctrl[hgs_pkg::GC_LSB +: hgs_pkg::GC_W];
   assign reset_delay_select = ctrl[hgs_pkg::RD_LSB +: hgs_pkg::SEL_W];

   // ---------------- Power-on reset and millisecond divider ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt <= '0;
         por_done <= 1'b0;
      end else if (!por_done) begin
         por_cnt <= por_cnt + 1'b1;
         por_done <= (por_cnt + 1'b1) >= 12'(hgs_pkg::POR_CYCLES);
      end
   end

   // One tick per millisecond; held in reset until supply is stable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt <= '0;
         ms_tick <= 1'b0;
      end else if (!por_done) begin
         ms_cnt <= '0;
         ms_tick <= 1'b0;
      end else if (ms_cnt == 18'(MS_CYCLES - 1)) begin
         ms_cnt <= '0;
         ms_tick <= 1'b1;
      end else begin
         ms_cnt <= ms_cnt + 1'b1;
         ms_tick <= 1'b0;
      end
   end

   // ---------------- Gate drive ----------------
   hgs_gate_sel u_gate_sel (
      .quick_select_hi(quick_select_hi),
      .quick_select_lo(quick_select_lo),
      .gate_current_code(gate_current_code),
      .next_gate_code(next_gate_code)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_drive_current <= hgs_pkg::GC_DEFAULT;
      end else begin
         gate_drive_current <= next_gate_code;
      end
   end

   // Gate held off until power-on reset completes so the FET cannot creep on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_out <= 1'b0;
      end else begin
         gate_out <= por_done && !undervoltage && !overvoltage && !overcurrent;
      end
   end

   // ---------------- Power-good ----------------
   assign fet_ok = !drain_high && !gate_low;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_ok_n <= 1'b1;
      end else begin
         supply_ok_n <= !(por_done && !undervoltage && !overvoltage
                          && !overcurrent && fet_ok);
      end
   end

   // ---------------- Rail goods ----------------
   for (genvar i = 0; i < 4; i++) begin : g_rail
      hgs_delay u_rail_dly (
         .pclk(pclk),
         .presetn(presetn),
         .por_clr(!por_done),
         .run(!rail_enable_in_n[i] && !overcurrent),
         .tick(ms_tick),
         .sel(ctrl[hgs_pkg::RAIL_LSB + 2*i +: hgs_pkg::SEL_W]),
         .done(rail_done[i])
      );

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rail_good_out_n[i] <= 1'b1;
         end else begin
            rail_good_out_n[i] <= !(rail_done[i] && !rail_enable_in_n[i]
                                    && !overcurrent);
         end
      end
   end

   // ---------------- Delayed system reset ----------------
   assign release_ok = por_done && !supply_ok_n && (rail_good_out_n == 4'h0);

   hgs_delay u_rst_dly (
      .pclk(pclk),
      .presetn(presetn),
      .por_clr(!por_done),
      .run(release_ok),
      .tick(ms_tick),
      .sel(reset_delay_select),
      .done(rst_done)
   );

   // Gated with release_ok too so a lost condition re-holds reset at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delayed_system_reset_n <= 1'b0;
      end else begin
         delayed_system_reset_n <= rst_done && release_ok;
      end
   end

   // ---------------- APB slave ----------------
   assign setup = psel && !penable;
   assign access = psel && penable && pready;
   assign addr_ok = paddr == hgs_pkg::ADDR_CTRL || paddr == hgs_pkg::ADDR_STATUS
                    || paddr == hgs_pkg::ADDR_INT_STAT || paddr == hgs_pkg::ADDR_INT_MASK
                    || paddr == hgs_pkg::ADDR_NVM;
   assign refuse = !addr_ok || (paddr == hgs_pkg::ADDR_NVM && !por_done);
   assign wr_en = access && pwrite && !pslverr;

   always_comb begin
      rd_val = '0;
      unique case (paddr)
         hgs_pkg::ADDR_CTRL: rd_val[hgs_pkg::CTRL_W-1:0] = ctrl;
         hgs_pkg::ADDR_STATUS: begin
            rd_val[hgs_pkg::ST_GATE] = gate_out;
            rd_val[hgs_pkg::ST_PG_N] = supply_ok_n;
            rd_val[hgs_pkg::ST_RAIL_LSB +: 4] = rail_good_out_n;
            rd_val[hgs_pkg::ST_RST_N] = delayed_system_reset_n;
            rd_val[hgs_pkg::ST_POR] = por_done;
            rd_val[hgs_pkg::ST_GC_LSB +: 4] = gate_drive_current;
         end
         hgs_pkg::ADDR_INT_STAT: rd_val[hgs_pkg::INT_W-1:0] = int_stat;
         hgs_pkg::ADDR_INT_MASK: rd_val[hgs_pkg::INT_W-1:0] = int_mask;
         hgs_pkg::ADDR_NVM: rd_val = por_done ? nvm_word : '0;
         default: rd_val = '0;
      endcase
   end

   // Answer in the access cycle right after setup: no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (setup) begin
         pready <= 1'b1;
         pslverr <= refuse;
         prdata <= (pwrite || refuse) ? 32'h0000_0000 : rd_val;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= hgs_pkg::CTRL_RESET;
      end else if (wr_en && paddr == hgs_pkg::ADDR_CTRL) begin
         ctrl <= pwdata[hgs_pkg::CTRL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask <= '0;
      end else if (wr_en && paddr == hgs_pkg::ADDR_INT_MASK) begin
         int_mask <= pwdata[hgs_pkg::INT_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nvm_word <= '0;
      end else if (wr_en && paddr == hgs_pkg::ADDR_NVM) begin
         nvm_word <= pwdata;
      end
   end

   // ---------------- Interrupts ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oc_q <= 1'b0;
      end else begin
         oc_q <= overcurrent;
      end
   end

   always_comb begin
      int_ev = '0;
      int_ev[hgs_pkg::INT_OC] = overcurrent && !oc_q;
      int_ev[hgs_pkg::INT_PG_LOST] = !supply_ok_n && por_done
                                      && (overcurrent || !fet_ok);
      int_ev[hgs_pkg::INT_RST_REL] = rst_done && release_ok && !delayed_system_reset_n;
      next_int_stat = int_stat;
      if (wr_en && paddr == hgs_pkg::ADDR_INT_STAT) begin
         next_int_stat = int_stat & ~pwdata[hgs_pkg::INT_W-1:0];
      end
      // An event in the clearing cycle wins
      next_int_stat = next_int_stat | int_ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat <= '0;
         irq <= 1'b0;
      end else begin
         int_stat <= next_int_stat;
         irq <= |(next_int_stat & int_mask);
      end
   end

   // ---------------- Assertions ----------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_gate_off;
      (undervoltage || overvoltage || overcurrent) |=> !gate_out;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("gate on during fault");

   property p_quick;
      {quick_select_hi, quick_select_lo} == 2'b01 ##1
      {quick_select_hi, quick_select_lo} == 2'b10 |=> gate_drive_current == hgs_pkg::QS_70UA;
   endproperty
   a_quick: assert property (p_quick) else $error("quick select ignored");

   property p_code;
      {quick_select_hi, quick_select_lo} == 2'b00
      |=> gate_drive_current == $past(gate_current_code);
   endproperty
   a_code: assert property (p_code) else $error("gate code not applied");

   property p_sw_write;
      wr_en && paddr == hgs_pkg::ADDR_CTRL && !quick_select_hi && !quick_select_lo
      ##1 !quick_select_hi && !quick_select_lo |=> gate_drive_current == $past(pwdata[3:0], 2);
   endproperty
   a_sw_write: assert property (p_sw_write) else $error("written code lost");

   property p_pg;
      !supply_ok_n |-> $past(!overcurrent && !undervoltage && !overvoltage && fet_ok);
   endproperty
   a_pg: assert property (p_pg) else $error("power good without conditions");

   property p_drain;
      drain_high |=> supply_ok_n;
   endproperty
   a_drain: assert property (p_drain) else $error("drain fault ignored");

   property p_gate_sense;
      gate_low |=> supply_ok_n;
   endproperty
   a_gate_sense: assert property (p_gate_sense) else $error("gate sense ignored");

   property p_por_hold;
      !por_done |=> !delayed_system_reset_n;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("reset released in por");

   property p_release;
      $rose(delayed_system_reset_n) |-> $past(release_ok) && $past(rst_done);
   endproperty
   a_release: assert property (p_release) else $error("early reset release");

   property p_nvm;
      setup && paddr == hgs_pkg::ADDR_NVM && !por_done |=> pslverr;
   endproperty
   a_nvm: assert property (p_nvm) else $error("nvm access not refused");

   property p_oc;
      overcurrent |=> supply_ok_n && rail_good_out_n == 4'hf
                      && (int_stat[hgs_pkg::INT_OC] || $past(oc_q));
   endproperty
   a_oc: assert property (p_oc) else $error("overcurrent not handled");

   property p_rail;
      $fell(rail_good_out_n[0]) |-> $past(rail_done[0] && !rail_enable_in_n[0]);
   endproperty
   a_rail: assert property (p_rail) else $error("rail good without delay");

   property p_restart;
      delayed_system_reset_n && !release_ok |=> !delayed_system_reset_n;
   endproperty
   a_restart: assert property (p_restart) else $error("reset not re-held");

   property p_tick;
      ms_tick |-> por_done ##1 !ms_tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick outside por");

   c_gate_on: cover property (!gate_out ##1 gate_out);
   c_rst_rel: cover property ($rose(delayed_system_reset_n));
   c_oc: cover property (gate_out ##1 overcurrent ##1 !gate_out);
   c_irq: cover property ($rose(irq));
endmodule : hgs_seq

// [tb_hotswap_gate_pgood_reset.sv]
// Self-checking testbench for the hot-swap gate, power-good and delayed reset block
`timescale 1ns/10ps
module tb_hotswap_gate_pgood_reset;
   localparam int MS = 10;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic undervoltage, overvoltage, overcurrent, drain_high, gate_low, qs_hi, qs_lo;
   logic f_drain, f_gate, gate_out, supply_ok_n, delayed_system_reset_n, irq;
   logic [3:0] rail_enable_in_n, gate_drive_current, rail_good_out_n, code;
   logic [1:0] q;
   logic [33:0] note;
   logic [33:0] exp_q[$];
   logic [3:0] qtab[4] = '{4'h0, 4'h0, 4'h6, 4'he};
   int dtab[4] = '{100, 500, 1000, 5000};
   int err_total = 0;
   int total_checks = 0;
   int seed = 16806;
   int i, n, s;

   hgs_seq #(.MS_CYCLES(MS)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .undervoltage(undervoltage),
      .overvoltage(overvoltage), .overcurrent(overcurrent), .drain_high(drain_high),
      .gate_low(gate_low), .quick_select_hi(qs_hi), .quick_select_lo(qs_lo),
      .rail_enable_in_n(rail_enable_in_n), .gate_out(gate_out),
      .gate_drive_current(gate_drive_current), .supply_ok_n(supply_ok_n),
      .rail_good_out_n(rail_good_out_n), .delayed_system_reset_n(delayed_system_reset_n),
      .irq(irq));

   hgs_plant plant (.pclk(pclk), .gate_out(gate_out), .supply_ok_n(supply_ok_n),
      .force_drain(f_drain), .force_gate_low(f_gate), .drain_high(drain_high),
      .gate_low(gate_low), .rail_enable_in_n(rail_enable_in_n));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic end_sim;
      if (err_total == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
      total_checks++;
      if (seen !== expv) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask : chk

   // One APB transfer; the expected answer is queued for the monitor
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic e, input logic [31:0] x);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      exp_q.push_back({!wr, e, x});
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
         if (k > 20) begin
            chk(32'h0, 32'h1);
            end_sim;
         end
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   always @(posedge pclk) begin
      if (psel && penable && pready) begin
         if (exp_q.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            note = exp_q.pop_front();
            chk({31'h0, pslverr}, {31'h0, note[32]});
            if (note[33]) chk(prdata, note[31:0]);
         end
      end
   end

   function automatic logic probe(input int k);
      case (k)
         0: return gate_out;
         1: return supply_ok_n;
         2: return rail_good_out_n === 4'h0;
         default: return delayed_system_reset_n;
      endcase
   endfunction : probe

   // Bounded wait; a hang is reported and ends the run
   task automatic wait_sig(input int k, input logic v, input int lim, output int cnt);
      cnt = 0;
      while (probe(k) !== v) begin
         @(posedge pclk);
         cnt++;
         if (cnt > lim) begin
            chk({31'h0, probe(k)}, {31'h0, v});
            end_sim;
         end
      end
   endtask : wait_sig

   // Delays run on a millisecond tick, so allow one tick of slack either way
   task automatic chk_rng(input int cnt, input int ms);
      chk({31'h0, cnt >= (ms - 1) * MS && cnt <= (ms + 1) * MS + 8}, 32'h1);
   endtask : chk_rng

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {undervoltage, overvoltage, overcurrent, qs_hi, qs_lo, f_drain, f_gate} = '0;
      repeat (12) @(posedge pclk);
      chk({31'h0, delayed_system_reset_n}, 32'h0);
      presetn <= 1'b1;
      apb(1'b0, hgs_pkg::ADDR_CTRL, 32'h0, 1'b0, 32'h4);
      apb(1'b0, hgs_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h43e);
      apb(1'b1, hgs_pkg::ADDR_NVM, 32'h5a, 1'b1, 32'h0);
      apb(1'b0, hgs_pkg::ADDR_NVM, 32'h0, 1'b1, 32'h0);
      apb(1'b0, 8'h14, 32'h0, 1'b1, 32'h0);
      for (i = 0; i < 8; i++) begin
         code = 4'($random(seed));
         q = 2'(i);
         apb(1'b1, hgs_pkg::ADDR_CTRL, {28'h0, code}, 1'b0, 32'h0);
         qs_hi <= q[1];
         qs_lo <= q[0];
         repeat (4) @(posedge pclk);
         chk({28'h0, gate_drive_current}, {28'h0, (q == 2'h0) ? code : qtab[q]});
      end
      qs_hi <= 1'b0;
      qs_lo <= 1'b0;
      apb(1'b1, hgs_pkg::ADDR_CTRL, 32'h4, 1'b0, 32'h0);
      wait_sig(0, 1'b1, 2200, n);
      for (i = 0; i < 2; i++) begin
         if (i == 0) undervoltage <= 1'b1;
         else overvoltage <= 1'b1;
         repeat (4) @(posedge pclk);
         chk({30'h0, gate_out, supply_ok_n}, 32'h1);
         undervoltage <= 1'b0;
         overvoltage <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      apb(1'b1, hgs_pkg::ADDR_NVM, 32'hc3a5, 1'b0, 32'h0);
      apb(1'b0, hgs_pkg::ADDR_NVM, 32'h0, 1'b0, 32'hc3a5);
      wait_sig(1, 1'b0, 50, n);
      wait_sig(2, 1'b1, 1300, n);
      chk_rng(n, 100);
      wait_sig(3, 1'b1, 1300, n);
      chk_rng(n, 100);
      for (s = 1; s < 4; s++) begin
         if (s == 3) apb(1'b1, hgs_pkg::ADDR_INT_MASK, 32'h1, 1'b0, 32'h0);
         apb(1'b1, hgs_pkg::ADDR_CTRL, {26'h0, 2'(s), 4'h4}, 1'b0, 32'h0);
         f_drain <= (s == 1);
         f_gate <= (s == 2);
         overcurrent <= (s == 3);
         repeat (5) @(posedge pclk);
         chk({25'h0, gate_out, supply_ok_n, rail_good_out_n, delayed_system_reset_n},
             {25'h0, s != 3, 1'b1, 4'hf, 1'b0});
         chk({31'h0, irq}, {31'h0, s == 3});
         {f_drain, f_gate, overcurrent} <= 3'h0;
         if (s == 3) begin
            apb(1'b0, hgs_pkg::ADDR_INT_STAT, 32'h0, 1'b0, 32'h7);
            apb(1'b1, hgs_pkg::ADDR_INT_STAT, 32'h7, 1'b0, 32'h0);
            apb(1'b0, hgs_pkg::ADDR_INT_STAT, 32'h0, 1'b0, 32'h0);
            repeat (3) @(posedge pclk);
            chk({31'h0, irq}, 32'h0);
         end
         wait_sig(2, 1'b1, 1300, n);
         wait_sig(3, 1'b1, dtab[s] * MS + 2 * MS + 50, n);
         chk_rng(n, dtab[s]);
      end
      end_sim;
   end
endmodule : tb_hotswap_gate_pgood_reset
